// File: verilog/cfg_bank_consts.svh
// Register map constants for the converter configuration bank
`ifndef CFG_BANK_CONSTS_SVH
`define CFG_BANK_CONSTS_SVH
`define ADDR_HYST        8'h55
`define ADDR_COFS        8'h60
`define ADDR_FOFS        8'h61
`define ADDR_MGAIN       8'h62
`define ADDR_FGAIN       8'h63
`define ADDR_SKEW        8'h64
`define ADDR_CTOFS       8'h70
`define ADDR_STEP        8'h71
`define ADDR_RSVZ        8'h72
`define ADDR_DRVFMT      8'h73
`define ADDR_LOOP        8'h74
`define ADDR_PARITY      8'h75
`define ADDR_PSEL        8'hC0
`define ADDR_RSVT        8'hC1
`define ADDR_P1L         8'hC2
`define ADDR_P1H         8'hC3
`define ADDR_P2L         8'hC4
`define ADDR_P2H         8'hC5
`define RST_HYST         8'h10
`define RST_SEED_MID     8'h80
`define RST_ZERO         8'h00
`define LOOP_RANGE_BIT   0
`define TEST_MODE_MSB    3
`define TEST_MODE_LSB    0
`define DRV_MODE_MSB     7
`define DRV_MODE_LSB     5
`define FMT_MSB          2
`define FMT_LSB          0
`define STEP_BIT         0
`endif

// File: verilog/cfg_bank_pkg.sv
// Types for the converter configuration bank
`default_nettype none
package cfg_bank_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [7:0] addr_t;
  typedef logic [3:0] test_mode_t;
endpackage
`default_nettype wire

// File: verilog/adc_spi_config_registers.sv
// Upper configuration register bank reached through the serial port byte interface
`default_nettype none
`include "cfg_bank_consts.svh"

module adc_spi_config_registers #(
  parameter int SEED_W = 8
) (
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_rst_n,
  input  wire logic                  i_clk_en,
  input  wire logic                  i_soft_rst,
  input  wire logic                  i_wr,
  input  wire logic                  i_rd,
  input  wire cfg_bank_pkg::addr_t   i_addr,
  input  wire cfg_bank_pkg::byte_t   i_wdata,
  input  wire logic                  i_parity_bit,
  output var cfg_bank_pkg::byte_t    o_rdata,
  output logic [SEED_W-1:0]          o_coarse_offset_seed,
  output logic [SEED_W-1:0]          o_fine_offset_seed,
  output logic [SEED_W-1:0]          o_medium_gain_seed,
  output logic [SEED_W-1:0]          o_fine_gain_seed,
  output logic [SEED_W-1:0]          o_sample_timing_seed,
  output var cfg_bank_pkg::byte_t    o_ac_power_hysteresis,
  output var cfg_bank_pkg::byte_t    o_core_timing_offset,
  output logic                       o_clock_edge_step,
  output logic [2:0]                 o_drive_mode,
  output logic [2:0]                 o_data_format,
  output logic                       o_loop_range_slow,
  output var cfg_bank_pkg::test_mode_t o_test_mode,
  output logic [15:0]                o_first_pattern,
  output logic [15:0]                o_second_pattern
);
  import cfg_bank_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  localparam int NREG = 16;
  localparam int I_HYST   = 0;
  localparam int I_COFS   = 1;
  localparam int I_FOFS   = 2;
  localparam int I_MGAIN  = 3;
  localparam int I_FGAIN  = 4;
  localparam int I_SKEW   = 5;
  localparam int I_CTOFS  = 6;
  localparam int I_STEP   = 7;
  localparam int I_DRVFMT = 8;
  localparam int I_LOOP   = 9;
  localparam int I_PSEL   = 10;
  localparam int I_P1L    = 11;
  localparam int I_P1H    = 12;
  localparam int I_P2L    = 13;
  localparam int I_P2H    = 14;
  localparam int I_NONE   = 15;

  byte_t regs_q [NREG];
  byte_t regs_d [NREG];
  byte_t parity_q;
  byte_t parity_d;
  byte_t rdata_q;
  byte_t rdata_d;
  logic  psync1_q;
  logic  psync2_q;

  // Address to storage index
  function automatic int reg_index(input addr_t a);
    unique case (a)
      `ADDR_HYST:   reg_index = I_HYST;
      `ADDR_COFS:   reg_index = I_COFS;
      `ADDR_FOFS:   reg_index = I_FOFS;
      `ADDR_MGAIN:  reg_index = I_MGAIN;
      `ADDR_FGAIN:  reg_index = I_FGAIN;
      `ADDR_SKEW:   reg_index = I_SKEW;
      `ADDR_CTOFS:  reg_index = I_CTOFS;
      `ADDR_STEP:   reg_index = I_STEP;
      `ADDR_DRVFMT: reg_index = I_DRVFMT;
      `ADDR_LOOP:   reg_index = I_LOOP;
      `ADDR_PSEL:   reg_index = I_PSEL;
      `ADDR_P1L:    reg_index = I_P1L;
      `ADDR_P1H:    reg_index = I_P1H;
      `ADDR_P2L:    reg_index = I_P2L;
      `ADDR_P2H:    reg_index = I_P2H;
      default:      reg_index = I_NONE;
    endcase
  endfunction

  // Reset value per index
  function automatic byte_t reset_val(input int i);
    if (i == I_HYST) begin
      reset_val = `RST_HYST;
    end else if (i == I_MGAIN || i == I_SKEW || i == I_CTOFS) begin
      reset_val = `RST_SEED_MID;
    end else begin
      reset_val = `RST_ZERO;
    end
  endfunction

  // Registers kept through soft reset
  function automatic logic soft_keep(input int i);
    soft_keep = (i == I_DRVFMT) || (i == I_LOOP);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    int widx;
    widx = reg_index(i_addr);
    for (int i = 0; i < NREG; i++) begin
      regs_d[i] = regs_q[i];
      if (i_soft_rst && !soft_keep(i)) begin
        regs_d[i] = reset_val(i);
      end else if (i_wr && widx == i && i != I_NONE) begin
        regs_d[i] = i_wdata;
      end
    end
    regs_d[I_NONE] = `RST_ZERO;
    parity_d = {7'h00, psync2_q};
    rdata_d  = rdata_q;
    if (i_rd) begin
      if (i_addr == `ADDR_PARITY) begin
        rdata_d = parity_q;
      end else begin
        rdata_d = regs_q[reg_index(i_addr)];
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      for (int i = 0; i < NREG; i++) begin
        regs_q[i] <= reset_val(i);
      end
      parity_q <= `RST_ZERO;
      rdata_q  <= `RST_ZERO;
      psync1_q <= 1'b0;
      psync2_q <= 1'b0;
    end else if (i_clk_en) begin
      regs_q   <= regs_d;
      parity_q <= parity_d;
      rdata_q  <= rdata_d;
      psync1_q <= i_parity_bit;
      psync2_q <= psync1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign o_rdata               = rdata_q;
  assign o_ac_power_hysteresis = regs_q[I_HYST];
  assign o_coarse_offset_seed  = SEED_W'(regs_q[I_COFS]);
  assign o_fine_offset_seed    = SEED_W'(regs_q[I_FOFS]);
  assign o_medium_gain_seed    = SEED_W'(regs_q[I_MGAIN]);
  assign o_fine_gain_seed      = SEED_W'(regs_q[I_FGAIN]);
  assign o_sample_timing_seed  = SEED_W'(regs_q[I_SKEW]);
  assign o_core_timing_offset  = regs_q[I_CTOFS];
  assign o_clock_edge_step     = regs_q[I_STEP][`STEP_BIT];
  assign o_drive_mode          = regs_q[I_DRVFMT][`DRV_MODE_MSB:`DRV_MODE_LSB];
  assign o_data_format         = regs_q[I_DRVFMT][`FMT_MSB:`FMT_LSB];
  assign o_loop_range_slow     = regs_q[I_LOOP][`LOOP_RANGE_BIT];
  assign o_test_mode           = regs_q[I_PSEL][`TEST_MODE_MSB:`TEST_MODE_LSB];
  assign o_first_pattern       = {regs_q[I_P1H], regs_q[I_P1L]};
  assign o_second_pattern      = {regs_q[I_P2H], regs_q[I_P2L]};

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  a_coarse_write: assert property (
    i_clk_en && i_wr && !i_soft_rst && i_addr == `ADDR_COFS
    |=> o_coarse_offset_seed == SEED_W'($past(i_wdata)))
    else $error("coarse seed write lost");
  a_coarse_soft: assert property (
    i_clk_en && i_soft_rst
    |=> o_coarse_offset_seed == SEED_W'(`RST_ZERO))
    else $error("coarse seed not reset");
  a_fine_ofs_write: assert property (
    i_clk_en && i_wr && !i_soft_rst && i_addr == `ADDR_FOFS
    |=> o_fine_offset_seed == SEED_W'($past(i_wdata)))
    else $error("fine offset write lost");
  a_fine_ofs_soft: assert property (
    i_clk_en && i_soft_rst
    |=> o_fine_offset_seed == SEED_W'(`RST_ZERO))
    else $error("fine offset not reset");
  a_mgain_write: assert property (
    i_clk_en && i_wr && !i_soft_rst && i_addr == `ADDR_MGAIN
    |=> o_medium_gain_seed == SEED_W'($past(i_wdata)))
    else $error("medium gain write lost");
  a_mgain_soft: assert property (
    i_clk_en && i_soft_rst
    |=> o_medium_gain_seed == SEED_W'(`RST_SEED_MID))
    else $error("medium gain not reset");
  a_mgain_read: assert property (
    i_clk_en && i_rd && i_addr == `ADDR_MGAIN
    |=> o_rdata == byte_t'($past(o_medium_gain_seed)))
    else $error("medium gain read wrong");
  a_fgain_write: assert property (
    i_clk_en && i_wr && !i_soft_rst && i_addr == `ADDR_FGAIN
    |=> o_fine_gain_seed == SEED_W'($past(i_wdata)))
    else $error("fine gain write lost");
  a_fgain_soft: assert property (
    i_clk_en && i_soft_rst
    |=> o_fine_gain_seed == SEED_W'(`RST_ZERO))
    else $error("fine gain not reset");
  a_skew_write: assert property (
    i_clk_en && i_wr && !i_soft_rst && i_addr == `ADDR_SKEW
    |=> o_sample_timing_seed == SEED_W'($past(i_wdata)))
    else $error("skew seed write lost");
  a_skew_soft: assert property (
    i_clk_en && i_soft_rst
    |=> o_sample_timing_seed == SEED_W'(`RST_SEED_MID))
    else $error("skew seed not reset");
  a_loop_write: assert property (
    i_clk_en && i_wr && !i_soft_rst && i_addr == `ADDR_LOOP
    |=> o_loop_range_slow == $past(i_wdata[`LOOP_RANGE_BIT]))
    else $error("loop range lost");
  a_test_write: assert property (
    i_clk_en && i_wr && !i_soft_rst && i_addr == `ADDR_PSEL
    |=> o_test_mode == $past(i_wdata[`TEST_MODE_MSB:`TEST_MODE_LSB]))
    else $error("test mode write lost");
  a_test_soft: assert property (
    i_clk_en && i_soft_rst
    |=> o_test_mode == test_mode_t'(`RST_ZERO))
    else $error("test mode not cleared");
  a_rsvd_read: assert property (
    i_clk_en && i_rd && (i_addr == `ADDR_RSVZ || i_addr == `ADDR_RSVT)
    |=> o_rdata == `RST_ZERO)
    else $error("reserved read nonzero");
  a_rsvd_wr_drop: assert property (
    i_clk_en && i_wr && !i_soft_rst && (i_addr == `ADDR_RSVZ || i_addr == `ADDR_RSVT)
    |=> $stable(o_test_mode) && $stable(o_first_pattern) && $stable(o_second_pattern))
    else $error("reserved write landed");
  a_loop_keep: assert property (
    i_clk_en && i_soft_rst && !i_wr
    |=> $stable(o_loop_range_slow) && $stable(o_drive_mode))
    else $error("mode lost");
  a_format_keep: assert property (
    i_clk_en && i_soft_rst && !i_wr
    |=> $stable(o_data_format))
    else $error("format lost");
  a_hyst_write: assert property (
    i_clk_en && i_wr && !i_soft_rst && i_addr == `ADDR_HYST
    |=> o_ac_power_hysteresis == $past(i_wdata))
    else $error("hysteresis write lost");
  a_hyst_soft: assert property (
    i_clk_en && i_soft_rst
    |=> o_ac_power_hysteresis == `RST_HYST)
    else $error("hysteresis not reset");
  a_ctofs_write: assert property (
    i_clk_en && i_wr && !i_soft_rst && i_addr == `ADDR_CTOFS
    |=> o_core_timing_offset == $past(i_wdata))
    else $error("timing offset write lost");
  a_ctofs_soft: assert property (
    i_clk_en && i_soft_rst
    |=> o_core_timing_offset == `RST_SEED_MID)
    else $error("timing offset not reset");
  a_step_write: assert property (
    i_clk_en && i_wr && !i_soft_rst && i_addr == `ADDR_STEP
    |=> o_clock_edge_step == $past(i_wdata[`STEP_BIT]))
    else $error("edge step write lost");
  a_step_soft: assert property (
    i_clk_en && i_soft_rst
    |=> !o_clock_edge_step)
    else $error("edge step not reset");
  a_drvfmt_write: assert property (
    i_clk_en && i_wr && !i_soft_rst && i_addr == `ADDR_DRVFMT
    |=> o_drive_mode == $past(i_wdata[`DRV_MODE_MSB:`DRV_MODE_LSB])
    && o_data_format == $past(i_wdata[`FMT_MSB:`FMT_LSB]))
    else $error("drive format write lost");
  a_pat1_low: assert property (
    i_clk_en && i_wr && !i_soft_rst && i_addr == `ADDR_P1L
    |=> o_first_pattern[7:0] == $past(i_wdata))
    else $error("first pattern low lost");
  a_pat1_high: assert property (
    i_clk_en && i_wr && !i_soft_rst && i_addr == `ADDR_P1H
    |=> o_first_pattern[15:8] == $past(i_wdata))
    else $error("first pattern high lost");
  a_pat2_low: assert property (
    i_clk_en && i_wr && !i_soft_rst && i_addr == `ADDR_P2L
    |=> o_second_pattern[7:0] == $past(i_wdata))
    else $error("second pattern low lost");
  a_pat2_high: assert property (
    i_clk_en && i_wr && !i_soft_rst && i_addr == `ADDR_P2H
    |=> o_second_pattern[15:8] == $past(i_wdata))
    else $error("second pattern high lost");
  a_pat_soft: assert property (
    i_clk_en && i_soft_rst
    |=> o_first_pattern == {`RST_ZERO, `RST_ZERO} && o_second_pattern == {`RST_ZERO, `RST_ZERO})
    else $error("patterns not reset");
  a_parity_upper: assert property (
    i_clk_en && i_rd && i_addr == `ADDR_PARITY
    |=> o_rdata[7:1] == 7'h00)
    else $error("check result upper bits set");
  a_rdata_hold: assert property (
    !(i_clk_en && i_rd)
    |=> $stable(o_rdata))
    else $error("read data moved without read");
  a_freeze_hold: assert property (
    !i_clk_en
    |=> $stable(o_rdata) && $stable(o_test_mode))
    else $error("state moved while disabled");

  c_seed_write: cover property (i_clk_en && i_wr && i_addr == `ADDR_MGAIN);
  c_soft_reset: cover property (i_clk_en && i_soft_rst);
  c_pattern_rd: cover property (i_clk_en && i_rd && i_addr == `ADDR_P1H);
  c_parity_rd:  cover property (i_clk_en && i_rd && i_addr == `ADDR_PARITY);
endmodule
`default_nettype wire

// File: bench/host_model.sv
// Host model issuing single-byte register write and read cycles
`default_nettype none
module host_model (
  input  wire logic                i_clk_sys,
  input  wire cfg_bank_pkg::byte_t i_rdata,
  output logic                     o_wr,
  output logic                     o_rd,
  output var cfg_bank_pkg::addr_t  o_addr,
  output var cfg_bank_pkg::byte_t  o_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  import cfg_bank_pkg::*;
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
  end
  task automatic wr(input addr_t a, input byte_t d);
    @(posedge i_clk_sys);
    o_wr <= 1'b1;
    o_addr <= a;
    o_wdata <= (a == 8'h72) ? 8'h00 : d;
    @(posedge i_clk_sys);
    o_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input addr_t a, output byte_t d);
    @(posedge i_clk_sys);
    o_rd <= 1'b1;
    o_addr <= a;
    @(posedge i_clk_sys);
    o_rd <= 1'b0;
    #1;
    d = i_rdata;
  endtask
endmodule
`default_nettype wire

// File: bench/adc_spi_config_registers_tb.sv
// Self-checking bench for the configuration register bank
`default_nettype none
module adc_spi_config_registers_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cfg_bank_pkg::*;
  logic       clk_sys = 1'b0;
  logic       rst_n = 1'b0;
  logic       clk_en = 1'b1;
  logic       soft_rst = 1'b0;
  logic       parity_bit = 1'b0;
  logic       wr, rd, loop_slow;
  addr_t      addr;
  byte_t      wdata, rdata, seen, med, skew;
  byte_t      cofs, fofs, fgain, hyst, ctofs;
  logic       step;
  logic [2:0] fmt;
  logic [15:0] pat2;
  test_mode_t tmode;
  logic [15:0] pat1;
  logic [2:0] drv;
  int         num_errors = 0;
  int         num_checks = 0;
  addr_t ra [18] = '{8'h55, 8'h60, 8'h61, 8'h62, 8'h63, 8'h64, 8'h70, 8'h71, 8'h72,
                     8'h73, 8'h74, 8'hC0, 8'hC1, 8'hC2, 8'hC3, 8'hC4, 8'hC5, 8'h56};
  byte_t rv [18] = '{8'h10, 8'h00, 8'h00, 8'h80, 8'h00, 8'h80, 8'h80, 8'h00, 8'h00,
                     8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  byte_t wv [18] = '{8'h69, 8'h5C, 8'h5D, 8'h5E, 8'h5F, 8'h58, 8'h4C, 8'h01, 8'h00,
                     8'hA5, 8'h01, 8'h08, 8'hFF, 8'hFE, 8'hFF, 8'hF8, 8'hF9, 8'hFF};
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  host_model u_host (.i_clk_sys(clk_sys), .i_rdata(rdata), .o_wr(wr), .o_rd(rd),
                     .o_addr(addr), .o_wdata(wdata));
  adc_spi_config_registers dut (
    .i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_clk_en(clk_en), .i_soft_rst(soft_rst),
    .i_wr(wr), .i_rd(rd), .i_addr(addr), .i_wdata(wdata), .i_parity_bit(parity_bit),
    .o_rdata(rdata), .o_coarse_offset_seed(cofs), .o_fine_offset_seed(fofs),
    .o_medium_gain_seed(med), .o_fine_gain_seed(fgain), .o_sample_timing_seed(skew),
    .o_ac_power_hysteresis(hyst), .o_core_timing_offset(ctofs), .o_clock_edge_step(step),
    .o_drive_mode(drv), .o_data_format(fmt), .o_loop_range_slow(loop_slow),
    .o_test_mode(tmode), .o_first_pattern(pat1), .o_second_pattern(pat2));
  task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    results();
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int i = 0; i < 18; i++) begin
      u_host.rd(ra[i], seen);
      check("reset read", seen, rv[i]);
    end
    check("gain out", med, 8'h80);
    check("skew out", skew, 8'h80);
    for (int i = 0; i < 18; i++) u_host.wr(ra[i], wv[i]);
    for (int i = 0; i < 18; i++) begin
      u_host.rd(ra[i], seen);
      check("readback", seen, (ra[i] == 8'hC1 || ra[i] == 8'h56) ? 8'h00 : wv[i]);
    end
    check("gain out", med, 8'h5E);
    check("skew out", skew, 8'h58);
    check("loop out", loop_slow, 1'b1);
    check("test mode", tmode, 4'h8);
    check("pattern", pat1, 16'hFFFE);
    check("drive", drv, 3'h5);
    check("coarse out", cofs, 8'h5C);
    check("fine ofs out", fofs, 8'h5D);
    check("fine gain out", fgain, 8'h5F);
    check("hyst out", hyst, 8'h69);
    check("timing ofs out", ctofs, 8'h4C);
    check("edge step out", step, 1'b1);
    check("format out", fmt, 3'h5);
    check("pattern two", pat2, 16'hF9F8);
    @(posedge clk_sys) clk_en <= 1'b0;
    u_host.wr(8'h62, 8'h11);
    @(posedge clk_sys) clk_en <= 1'b1;
    u_host.rd(8'h62, seen);
    check("frozen", seen, 8'h5E);
    @(posedge clk_sys) soft_rst <= 1'b1;
    @(posedge clk_sys) soft_rst <= 1'b0;
    u_host.rd(8'h73, seen);
    check("soft 73", seen, 8'hA5);
    u_host.rd(8'h74, seen);
    check("soft 74", seen, 8'h01);
    u_host.rd(8'h62, seen);
    check("soft 62", seen, 8'h80);
    u_host.rd(8'h60, seen);
    check("soft 60", seen, 8'h00);
    check("soft hyst", hyst, 8'h10);
    check("soft timing ofs", ctofs, 8'h80);
    check("soft format", fmt, 3'h5);
    @(posedge clk_sys) parity_bit <= 1'b1;
    repeat (3) @(posedge clk_sys);
    u_host.rd(8'h75, seen);
    check("parity", seen, 8'h01);
    @(posedge clk_sys) rst_n <= 1'b0;
    @(posedge clk_sys) rst_n <= 1'b1;
    u_host.rd(8'h74, seen);
    check("full 74", seen, 8'h00);
    results();
  end
endmodule
`default_nettype wire
